// ==== shared/rate_cfg_pkg.sv ====
package rate_cfg_pkg;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [6:0] ADDR_HP_CTRL = 7'h21;
    localparam logic [6:0] ADDR_IRQ_CTRL = 7'h22;
    localparam logic [6:0] ADDR_FMT_CTRL = 7'h23;
    localparam logic [6:0] ADDR_PATH_CTRL = 7'h24;
    localparam logic [6:0] ADDR_REF = 7'h25;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [1:0] BOOT_UPPER_DEFAULT = 2'h0;

    // ********************************
    // Field codes
    // ********************************
    localparam logic [1:0] HPM_NORMAL_RST = 2'h0;
    localparam logic [1:0] HPM_REFERENCE = 2'h1;
    localparam logic [1:0] HPM_NORMAL = 2'h2;
    localparam logic [1:0] HPM_AUTORESET = 2'h3;
    localparam logic [3:0] CUTOFF_MAX = 4'h9;
    localparam logic [1:0] ST_NORMAL = 2'h0;
    localparam logic [1:0] ST_POS = 2'h1;
    localparam logic [1:0] ST_UNDEF = 2'h2;
    localparam logic [1:0] ST_NEG = 2'h3;
    localparam int BOOT_CYCLES = 4;

    // Path choice presented to the data path
    typedef enum logic [1:0] {
        PATH_RAW = 2'b00,
        PATH_HP = 2'b01,
        PATH_LP = 2'b10,
        PATH_LP_HP = 2'b11
    } path_t;

    // Register bus request; answer comes back on rdata and rdata_valid
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Decoded controls toward the sensor data path
    typedef struct packed {
        logic [1:0] hp_mode;
        logic [3:0] hp_cutoff_code;
        logic byte_order_sel;
        logic [1:0] selftest_sel;
        logic serial_wire_mode;
        logic fifo_enable;
        path_t output_path;
        path_t irq_path;
        logic [7:0] reference;
        logic use_reference;
    } ctrl_out_t;

    // Conditions that may drive the pins
    typedef struct packed {
        logic motion_irq;
        logic boot_busy;
        logic new_data;
        logic fifo_watermark;
        logic fifo_overrun;
        logic fifo_empty;
    } pin_src_t;

endpackage

// ==== hdl/irq_pin_drive.sv ====
`timescale 1ns/100ps
`default_nettype none
module irq_pin_drive
    import rate_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic assert_level,
    input wire logic active_low,
    input wire logic open_drain,
    output logic pin_out,
    output logic pin_oe_n
);

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic out;
        logic oe_n;
    } drv_state_t;

    drv_state_t state;
    drv_state_t next_state;
    logic level;

    always_comb begin
        level = assert_level ^ active_low;
        next_state.out = level;
        // Open drain releases the pin instead of driving high
        if (open_drain) begin
            next_state.out = 1'b0;
            next_state.oe_n = level;
        end else begin
            next_state.oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '{out: 1'b0, oe_n: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign pin_out = state.out;
    assign pin_oe_n = state.oe_n;

endmodule
`default_nettype wire

// ==== hdl/rate_sensor_filter_int_config.sv ====
// Function
// - Modes 00/10 normal; 00 resets on read
// - Mode 01 reference; 11 auto-reset on interrupt
// - Cut-off code 0000 to 1001 selects corner
// - Enable gates motion interrupt onto pin one
// - Enable shows boot status on pin one
// - Polarity bit: 0 high, 1 low, pin one only; pin two always active high
// - Drive bit: 0 push-pull, 1 open-drain
// - Enable routes new data to pin two
// - Three enables route FIFO conditions to pin two
// - Byte order bit selects low/high first
// - Self-test field 00 normal, 01 plus, 11 minus
// - Serial mode bit: 0 four-wire, 1 three-wire
// - Reboot bit reloads stored calibration content
// - FIFO enable bit turns FIFO on
// - Filter enable inserts high-pass after low-pass
// - Output select 00 raw, 01 high-pass
// - Output select upper bit uses second low-pass
// - Interrupt select 00 raw, 01 high-pass
// - Interrupt select upper bit uses low-pass
`timescale 1ns/100ps
`default_nettype none
module rate_sensor_filter_int_config
    import rate_cfg_pkg::*;
#(
    parameter logic [6:0] FILTER_RESET_ADDR = 7'h25,
    parameter int BOOT_LEN = BOOT_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire reg_req_t req,
    output logic [7:0] rdata,
    output logic rdata_valid,
    input wire pin_src_t src,
    input wire logic [7:0] calib_upper,
    output ctrl_out_t ctrl,
    output logic filter_reset,
    output logic boot_busy,
    output logic irq_pin_one_out,
    output logic irq_pin_one_oe_n,
    output logic irq_pin_two_out,
    output logic irq_pin_two_oe_n
);

    // ********************************
    // Helpers
    // ********************************
    function automatic path_t path_pick(input logic [1:0] sel, input logic hp_en);
        if (sel[1]) begin
            path_pick = hp_en ? PATH_LP_HP : PATH_LP;
        end else begin
            path_pick = sel[0] ? PATH_HP : PATH_RAW;
        end
    endfunction

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic [1:0] hp_upper;
        logic [1:0] hp_mode;
        logic [3:0] hp_cutoff_code;
        logic [7:0] irq_ctrl;
        logic byte_order_sel;
        logic [1:0] selftest_sel;
        logic serial_wire_mode;
        logic reboot;
        logic fifo_enable;
        logic hp_enable;
        logic [1:0] irq_path_sel;
        logic [1:0] output_path_sel;
        logic [7:0] reference;
        logic [3:0] boot_cnt;
        logic [7:0] rdata;
        logic rdata_valid;
        logic filter_reset;
    } cfg_state_t;

    cfg_state_t state;
    cfg_state_t next_state;
    logic pin1_level;
    logic pin2_level;

    // ********************************
    // Register access
    // ********************************
    always_comb begin
        next_state = state;
        next_state.rdata_valid = req.rd;
        next_state.filter_reset = 1'b0;
        if (req.rd && req.addr == FILTER_RESET_ADDR && state.hp_mode == HPM_NORMAL_RST) begin
            next_state.filter_reset = 1'b1;
        end
        if (state.hp_mode == HPM_AUTORESET && src.motion_irq) begin
            next_state.filter_reset = 1'b1;
        end
        if (req.rd) begin
            case (req.addr)
                ADDR_HP_CTRL: next_state.rdata = {state.hp_upper, state.hp_mode,
                    state.hp_cutoff_code};
                ADDR_IRQ_CTRL: next_state.rdata = state.irq_ctrl;
                ADDR_FMT_CTRL: next_state.rdata = {1'b0, state.byte_order_sel, 3'h0,
                    state.selftest_sel, state.serial_wire_mode};
                ADDR_PATH_CTRL: next_state.rdata = {state.reboot, state.fifo_enable,
                    1'b0, state.hp_enable, state.irq_path_sel, state.output_path_sel};
                ADDR_REF: next_state.rdata = state.reference;
                default: next_state.rdata = 8'h00;
            endcase
        end
        if (state.reboot) begin
            if (state.boot_cnt == 4'(BOOT_LEN - 1)) begin
                next_state.reboot = 1'b0;
                next_state.boot_cnt = 4'h0;
                next_state.hp_upper = calib_upper[7:6];
            end else begin
                next_state.boot_cnt = state.boot_cnt + 4'h1;
            end
        end
        if (req.wr) begin
            case (req.addr)
                ADDR_HP_CTRL: begin
                    next_state.hp_mode = req.wdata[5:4];
                    next_state.hp_cutoff_code = req.wdata[3:0];
                end
                ADDR_IRQ_CTRL: next_state.irq_ctrl = req.wdata;
                ADDR_FMT_CTRL: begin
                    next_state.byte_order_sel = req.wdata[6];
                    next_state.selftest_sel = req.wdata[2:1];
                    next_state.serial_wire_mode = req.wdata[0];
                end
                ADDR_PATH_CTRL: begin
                    // Host request wins over boot completion
                    next_state.reboot = next_state.reboot | req.wdata[7];
                    next_state.fifo_enable = req.wdata[6];
                    next_state.hp_enable = req.wdata[4];
                    next_state.irq_path_sel = req.wdata[3:2];
                    next_state.output_path_sel = req.wdata[1:0];
                end
                ADDR_REF: next_state.reference = req.wdata;
                default: next_state = next_state;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
            state.hp_upper <= BOOT_UPPER_DEFAULT;
            state.reference <= RST_CTRL;
        end else begin
            state <= next_state;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    always_comb begin
        ctrl.hp_mode = state.hp_mode;
        ctrl.hp_cutoff_code = state.hp_cutoff_code;
        ctrl.byte_order_sel = state.byte_order_sel;
        ctrl.selftest_sel = state.selftest_sel;
        ctrl.serial_wire_mode = state.serial_wire_mode;
        ctrl.fifo_enable = state.fifo_enable;
        ctrl.output_path = path_pick(state.output_path_sel, state.hp_enable);
        ctrl.irq_path = path_pick(state.irq_path_sel, state.hp_enable);
        ctrl.reference = state.reference;
        ctrl.use_reference = (state.hp_mode == HPM_REFERENCE);
    end

    assign pin1_level = (state.irq_ctrl[7] & src.motion_irq) | (state.irq_ctrl[6] & state.reboot);
    assign pin2_level = (state.irq_ctrl[3] & src.new_data) | (state.irq_ctrl[2] & src.fifo_watermark)
        | (state.irq_ctrl[1] & src.fifo_overrun) | (state.irq_ctrl[0] & src.fifo_empty);

    irq_pin_drive u_pin_one (
        .clk(clk),
        .rst(rst),
        .assert_level(pin1_level),
        .active_low(state.irq_ctrl[5]),
        .open_drain(state.irq_ctrl[4]),
        .pin_out(irq_pin_one_out),
        .pin_oe_n(irq_pin_one_oe_n)
    );

    irq_pin_drive u_pin_two (
        .clk(clk),
        .rst(rst),
        .assert_level(pin2_level),
        .active_low(1'b0),
        .open_drain(state.irq_ctrl[4]),
        .pin_out(irq_pin_two_out),
        .pin_oe_n(irq_pin_two_oe_n)
    );

    assign rdata = state.rdata;
    assign rdata_valid = state.rdata_valid;
    assign filter_reset = state.filter_reset;
    assign boot_busy = state.reboot;

    // ********************************
    // Checks
    // ********************************
    a_ref_write_held: assert property (@(posedge clk) disable iff (rst)
        req.wr && req.addr == ADDR_REF |=> ctrl.reference == $past(req.wdata))
        else $error("reference not stored");
    a_mode_read_reset: assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == FILTER_RESET_ADDR && state.hp_mode == HPM_NORMAL_RST
        |=> filter_reset)
        else $error("filter reset missing");
    a_auto_reset: assert property (@(posedge clk) disable iff (rst)
        state.hp_mode == HPM_AUTORESET && src.motion_irq |=> filter_reset)
        else $error("auto reset missing");
    a_out_path_raw: assert property (@(posedge clk) disable iff (rst)
        state.output_path_sel == 2'h0 |-> ctrl.output_path == PATH_RAW)
        else $error("output path wrong");
    a_irq_path_lp: assert property (@(posedge clk) disable iff (rst)
        state.irq_path_sel[1] && !state.hp_enable |-> ctrl.irq_path == PATH_LP)
        else $error("irq path wrong");
    a_pin_one_pol: assert property (@(posedge clk) disable iff (rst)
        !state.irq_ctrl[4] && $stable(state.irq_ctrl) |=>
        irq_pin_one_out == ($past(pin1_level) ^ $past(state.irq_ctrl[5])))
        else $error("pin one level wrong");
    sequence s_boot_busy;
        boot_busy [*4];
    endsequence
    sequence s_boot_loaded;
        !boot_busy && state.hp_upper == $past(calib_upper[7:6]);
    endsequence
    a_boot_ends: assert property (@(posedge clk)
        disable iff (rst || (req.wr && req.addr == ADDR_PATH_CTRL))
        $rose(boot_busy) |-> s_boot_busy ##1 s_boot_loaded)
        else $error("reboot did not end");
    a_upper_kept: assert property (@(posedge clk) disable iff (rst)
        req.wr && req.addr == ADDR_HP_CTRL && !state.reboot |=> $stable(state.hp_upper))
        else $error("upper bits changed");
    a_pin_one_boot: assert property (@(posedge clk) disable iff (rst)
        state.irq_ctrl[6] && state.reboot && !state.irq_ctrl[5] && !state.irq_ctrl[4]
        |=> irq_pin_one_out)
        else $error("boot status missing");
    a_open_drain: assert property (@(posedge clk) disable iff (rst)
        state.irq_ctrl[4] |=> !irq_pin_one_out && !irq_pin_two_out
        && irq_pin_one_oe_n == ($past(pin1_level) ^ $past(state.irq_ctrl[5]))
        && irq_pin_two_oe_n == $past(pin2_level))
        else $error("open drain drive wrong");
    a_pin_two_route: assert property (@(posedge clk) disable iff (rst)
        !state.irq_ctrl[4] |=> irq_pin_two_out == $past(pin2_level) && !irq_pin_two_oe_n)
        else $error("pin two level wrong");
    a_fmt_fields: assert property (@(posedge clk) disable iff (rst)
        req.wr && req.addr == ADDR_FMT_CTRL |=> ctrl.byte_order_sel == $past(req.wdata[6])
        && ctrl.selftest_sel == $past(req.wdata[2:1])
        && ctrl.serial_wire_mode == $past(req.wdata[0]))
        else $error("format fields wrong");
    a_fifo_enable: assert property (@(posedge clk) disable iff (rst)
        req.wr && req.addr == ADDR_PATH_CTRL |=> ctrl.fifo_enable == $past(req.wdata[6]))
        else $error("fifo enable wrong");

endmodule
`default_nettype wire

// ==== verification/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model
    import rate_cfg_pkg::*;
(
    input wire logic clk,
    output var reg_req_t req
);
    initial req = '0;
    // callers keep boot bits; only t_format writes reserved bits
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
    endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rate_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req;
    pin_src_t src = '0;
    logic [7:0] calib_upper = 8'hc0;
    logic [7:0] rdata;
    logic rdata_valid, filter_reset, boot_busy;
    logic p1, p1_oe_n, p2, p2_oe_n;
    ctrl_out_t ctrl;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    host_model host (.clk(clk), .req(req));
    rate_sensor_filter_int_config DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .rdata_valid(rdata_valid), .src(src), .calib_upper(calib_upper), .ctrl(ctrl),
        .filter_reset(filter_reset), .boot_busy(boot_busy), .irq_pin_one_out(p1),
        .irq_pin_one_oe_n(p1_oe_n), .irq_pin_two_out(p2), .irq_pin_two_oe_n(p2_oe_n));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        host.rd(a);
        chk(rdata_valid, 1);
        chk(rdata, exp);
    endtask
    task automatic pins(input logic [7:0] cfg, input pin_src_t s, input logic [3:0] exp);
        host.wr(ADDR_IRQ_CTRL, cfg);
        @(posedge clk);
        src <= s;
        repeat (2) @(posedge clk);
        #1;
        chk({p1, p1_oe_n, p2, p2_oe_n}, exp);
    endtask
    function automatic path_t exp_path(input logic hpen, input logic [1:0] s);
        return s[1] ? (hpen ? PATH_LP_HP : PATH_LP) : (s[0] ? PATH_HP : PATH_RAW);
    endfunction
    task automatic t_reset_values();
        rd_chk(ADDR_HP_CTRL, 8'h00);
        rd_chk(ADDR_IRQ_CTRL, 8'h00);
        rd_chk(ADDR_FMT_CTRL, 8'h00);
        rd_chk(ADDR_PATH_CTRL, 8'h00);
        rd_chk(ADDR_REF, 8'h00);
        chk({p1, p1_oe_n, p2, p2_oe_n}, 4'h0);
    endtask
    task automatic t_filter_modes();
        for (int m = 0; m < 4; m++) begin
            host.wr(ADDR_HP_CTRL, {2'b00, m[1:0], CUTOFF_MAX});
            chk({ctrl.hp_mode, ctrl.hp_cutoff_code}, {m[1:0], 4'h9});
            chk(ctrl.use_reference, m == 1);
            rd_chk(ADDR_REF, 8'ha5 * m[1:0]);
            chk(filter_reset, m == 0);
            host.wr(ADDR_REF, 8'ha5 * (m[1:0] + 2'd1));
            chk(ctrl.reference, 8'(8'ha5 * (m[1:0] + 2'd1)));
        end
    endtask
    task automatic t_format();
        host.wr(ADDR_FMT_CTRL, 8'hff);
        rd_chk(ADDR_FMT_CTRL, 8'h47);
        chk({ctrl.byte_order_sel, ctrl.serial_wire_mode}, 2'b11);
        for (int s = 0; s < 4; s++) begin
            host.wr(ADDR_FMT_CTRL, {5'b0, s[1:0], 1'b0});
            chk({ctrl.selftest_sel, ctrl.byte_order_sel, ctrl.serial_wire_mode}, {s[1:0], 2'b00});
        end
    endtask
    task automatic t_paths();
        for (int i = 0; i < 8; i++) begin
            host.wr(ADDR_PATH_CTRL, {1'b0, i[0], 1'b0, i[2], i[1:0], ~i[1:0]});
            chk(ctrl.fifo_enable, i[0]);
            chk(ctrl.irq_path, exp_path(i[2], i[1:0]));
            chk(ctrl.output_path, exp_path(i[2], ~i[1:0]));
        end
        rd_chk(ADDR_PATH_CTRL, 8'h5c);
        rd_chk(7'h26, 8'h00);
    endtask
    task automatic t_pins();
        pins(8'h80, 6'h20, 4'h8);
        pins(8'h00, 6'h20, 4'h0);
        pins(8'ha0, 6'h20, 4'h0);
        pins(8'ha0, 6'h00, 4'h8);
        pins(8'h90, 6'h20, 4'h4);
        pins(8'h90, 6'h00, 4'h0);
        pins(8'h08, 6'h08, 4'h2);
        pins(8'h04, 6'h04, 4'h2);
        pins(8'h02, 6'h02, 4'h2);
        pins(8'h01, 6'h01, 4'h2);
        pins(8'h07, 6'h08, 4'h0);
        pins(8'h11, 6'h01, 4'h1);
    endtask
    task automatic t_reboot();
        int n;
        host.wr(ADDR_IRQ_CTRL, 8'h40);
        host.wr(ADDR_HP_CTRL, 8'h13);
        host.wr(ADDR_PATH_CTRL, 8'h80);
        chk(boot_busy, 1);
        @(posedge clk);
        #1;
        chk(p1, 1);
        n = 0;
        while (boot_busy === 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, BOOT_CYCLES - 1);
        rd_chk(ADDR_HP_CTRL, 8'hd3);
    endtask
    task final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_filter_modes();
        t_format();
        t_paths();
        t_pins();
        t_reboot();
        final_report();
    end
endmodule
`default_nettype wire
